//--- ocfg_pkg.sv
// Shared constants and types for the oscillator and PLL configuration block
package ocfg_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_PLL      = 8'h10;
  localparam logic [7:0] OFF_SLOW_INT = 8'h18;
  localparam logic [7:0] OFF_XTAL     = 8'h1c;
  localparam logic [7:0] OFF_TRIM     = 8'h20;
  localparam logic [7:0] OFF_FAST     = 8'h24;
  localparam logic [7:0] OFF_STATUS   = 8'h28;

  // Reset values
  localparam logic [7:0] RST_PLL      = 8'h00;
  localparam logic [7:0] RST_SLOW_INT = 8'h00;
  localparam logic [7:0] RST_XTAL     = 8'h00;
  localparam logic [5:0] RST_TRIM     = 6'h00;

  // Field positions
  localparam int KEEP_BIT    = 7;
  localparam int PLL_SRC_BIT = 6;
  localparam int XTAL_SU_LSB = 4;
  localparam int XTAL_SEL    = 2;
  localparam int XTAL_LP     = 1;
  localparam int XTAL_EN     = 0;
  localparam int TRIM_SIGN   = 5;
  localparam int AUTO_EN_BIT = 0;

  // PLL ratio codes
  localparam logic [1:0] RATIO_OFF = 2'h0;
  localparam logic [1:0] RATIO_X2  = 2'h1;
  localparam logic [1:0] RATIO_X3  = 2'h2;

  // Timing: reference period and trim refresh bound
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TRIM_WAIT_NS   = 3000;
  localparam int TRIM_MAIN_CYC  = 3;
  localparam int TRIM_REFRESH_CYC = TRIM_WAIT_NS / CLK_PERIOD_NS + TRIM_MAIN_CYC;

  // Oscillator cycles from request to delivered output
  localparam logic [2:0] PLL_AVAIL  = 3'h2;
  localparam logic [2:0] SLOW_AVAIL = 3'h4;
  localparam logic [2:0] XTAL_AVAIL = 3'h3;

  // Channel indices
  localparam int CH_PLL  = 0;
  localparam int CH_SLOW = 1;
  localparam int CH_XTAL = 2;
  localparam int N_CH    = 3;

  // Device power modes
  typedef enum logic [1:0] {
    MODE_ACTIVE  = 2'b00,
    MODE_IDLE    = 2'b01,
    MODE_STANDBY = 2'b10,
    MODE_PDOWN   = 2'b11
  } ocfg_mode_t;

  // PLL control fields
  typedef struct packed {
    logic       keep_running_in_sleep;
    logic       src_external;
    logic [1:0] pll_ratio_sel;
  } ocfg_pll_t;

  // Crystal oscillator control fields
  typedef struct packed {
    logic       keep_running_in_sleep;
    logic [1:0] crystal_startup_cycles;
    logic       external_clock_in;
    logic       low_power_drive;
    logic       enable;
  } ocfg_xtal_t;

endpackage : ocfg_pkg

//--- ocfg_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module ocfg_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Level changes only when stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_level <= 1'b0;
    end else if (stage2 == stage3) begin
      o_level <= stage2;
    end
  end

endmodule : ocfg_sync

//--- ocfg_regs.sv
// Oscillator trim, PLL and 32.768 kHz oscillator configuration with APB slave
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
// How it works
// - trim holds signed -32 to +31 offset
// - top two trim bits mirror bit 5
// - auto-tune on blocks software trim writes
// - auto-tune off reloads trim within bound
// - PLL keep bit selects running in all modes but power-down, or on-request
// - running PLL delivered two PLL cycles later
// - PLL source: fast oscillator or external clock
// - ratio 0 off, 1 times two, 2 times three
// - slow internal keep bit runs all modes
// - running slow oscillator delivered after four cycles
// - crystal keep bit matters only when enabled
// - crystal output within three cycles after start-up
// - start-up code selects 1k/16k/32k/64k cycles
// - start-up and select frozen while enabled/stable
// - select crystal pair or external clock
// - low-power bit drives crystal gently
// - enable starts crystal, takes both pins
// - auto-tune bit enables crystal trimming
module ocfg_regs #(
  parameter int SU_1K  = 1024,
  parameter int SU_16K = 16384,
  parameter int SU_32K = 32768,
  parameter int SU_64K = 65536
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_cfg_unlock,
  input  wire logic [1:0]  i_sleep_mode,
  input  wire logic [5:0]  i_auto_trim,
  input  wire logic [2:0]  i_osc_req,
  input  wire logic [2:0]  i_osc_clk,
  output logic      [5:0]  o_fast_trim,
  output logic             o_crystal_lock_trim_en,
  output logic             o_pll_src_external,
  output logic      [1:0]  o_pll_ratio_sel,
  output logic             o_low_power_drive,
  output logic             o_external_clock_in,
  output logic             o_crystal_pin_takeover,
  output logic             o_slow_crystal_stable_flag,
  output logic      [2:0]  o_osc_run,
  output logic      [2:0]  o_osc_grant
);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  ocfg_pkg::ocfg_pll_t  pll;
  ocfg_pkg::ocfg_xtal_t xtal;
  ocfg_pkg::ocfg_mode_t mode;
  logic                 slow_keep;
  logic [5:0]           trim;
  logic                 auto_en;
  logic                 xtal_stable;
  logic [16:0]          su_count;
  logic [16:0]          su_target;
  logic [2:0]           run;
  logic [2:0]           osc_level;
  logic [2:0]           osc_level_d;
  logic [2:0]           osc_rise;
  logic [2:0]           avail [3];
  logic                 wr_en;
  logic                 setup;
  logic                 hit;
  logic [7:0]           rd_byte;
  logic                 locked_xtal;

  assign mode = ocfg_pkg::ocfg_mode_t'(i_sleep_mode);

  // APB phases
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite;

  // Address decode and read mux
  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    if (i_paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else begin
      unique case (i_paddr)
        ocfg_pkg::OFF_PLL:      rd_byte = {pll.keep_running_in_sleep, pll.src_external,
                                           4'h0, pll.pll_ratio_sel};
        ocfg_pkg::OFF_SLOW_INT: rd_byte = {slow_keep, 7'h00};
        ocfg_pkg::OFF_XTAL:     rd_byte = {xtal.keep_running_in_sleep, 1'b0,
                                           xtal.crystal_startup_cycles, 1'b0,
                                           xtal.external_clock_in, xtal.low_power_drive,
                                           xtal.enable};
        ocfg_pkg::OFF_TRIM:     rd_byte = {trim[ocfg_pkg::TRIM_SIGN],
                                           trim[ocfg_pkg::TRIM_SIGN], trim};
        ocfg_pkg::OFF_FAST:     rd_byte = {7'h00, auto_en};
        ocfg_pkg::OFF_STATUS:   rd_byte = {4'h0, xtal_stable, run};
        default:                hit = 1'b0;
      endcase
    end
  end

  // Zero-wait answer: ready in the access cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      if (setup) begin
        o_prdata  <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        o_pslverr <= !hit;
      end else if (o_pready) begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // PLL control, protected
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pll <= ocfg_pkg::ocfg_pll_t'({ocfg_pkg::RST_PLL[7:6], ocfg_pkg::RST_PLL[1:0]});
    end else if (wr_en && i_cfg_unlock && i_paddr == ocfg_pkg::OFF_PLL) begin
      pll.keep_running_in_sleep <= i_pwdata[ocfg_pkg::KEEP_BIT];
      pll.src_external          <= i_pwdata[ocfg_pkg::PLL_SRC_BIT];
      pll.pll_ratio_sel         <= i_pwdata[1:0];
    end
  end

  // Slow internal oscillator control, protected
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      slow_keep <= ocfg_pkg::RST_SLOW_INT[ocfg_pkg::KEEP_BIT];
    end else if (wr_en && i_cfg_unlock && i_paddr == ocfg_pkg::OFF_SLOW_INT) begin
      slow_keep <= i_pwdata[ocfg_pkg::KEEP_BIT];
    end
  end

  // Start-up code and source select freeze
  assign locked_xtal = xtal.enable || xtal_stable;

  // Crystal control, protected, partly frozen
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      xtal <= ocfg_pkg::ocfg_xtal_t'({ocfg_pkg::RST_XTAL[7], ocfg_pkg::RST_XTAL[5:4],
                                      ocfg_pkg::RST_XTAL[2:0]});
    end else if (wr_en && i_cfg_unlock && i_paddr == ocfg_pkg::OFF_XTAL) begin
      xtal.keep_running_in_sleep <= i_pwdata[ocfg_pkg::KEEP_BIT];
      xtal.low_power_drive       <= i_pwdata[ocfg_pkg::XTAL_LP];
      xtal.enable                <= i_pwdata[ocfg_pkg::XTAL_EN];
      if (!locked_xtal) begin
        xtal.crystal_startup_cycles <= i_pwdata[ocfg_pkg::XTAL_SU_LSB +: 2];
        xtal.external_clock_in      <= i_pwdata[ocfg_pkg::XTAL_SEL];
      end
    end
  end

  // Auto-tune enable
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      auto_en <= 1'b0;
    end else if (wr_en && i_paddr == ocfg_pkg::OFF_FAST) begin
      auto_en <= i_pwdata[ocfg_pkg::AUTO_EN_BIT];
    end
  end

  // Trim: locked under auto-tune, reloaded when auto-tune turns off
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      trim <= ocfg_pkg::RST_TRIM;
    end else if (wr_en && i_paddr == ocfg_pkg::OFF_FAST && auto_en
                 && !i_pwdata[ocfg_pkg::AUTO_EN_BIT]) begin
      trim <= i_auto_trim;
    end else if (wr_en && i_paddr == ocfg_pkg::OFF_TRIM && !auto_en) begin
      trim <= i_pwdata[5:0];
    end
  end

  // Run conditions per oscillator
  always_comb begin
    run[ocfg_pkg::CH_PLL] = (pll.pll_ratio_sel == ocfg_pkg::RATIO_X2
                             || pll.pll_ratio_sel == ocfg_pkg::RATIO_X3)
                            && (i_osc_req[ocfg_pkg::CH_PLL]
                                || (pll.keep_running_in_sleep
                                    && mode != ocfg_pkg::MODE_PDOWN));
    run[ocfg_pkg::CH_SLOW] = i_osc_req[ocfg_pkg::CH_SLOW] || slow_keep;
    run[ocfg_pkg::CH_XTAL] = xtal.enable
                             && (xtal.keep_running_in_sleep
                                 || (i_osc_req[ocfg_pkg::CH_XTAL]
                                     && (mode == ocfg_pkg::MODE_ACTIVE
                                         || mode == ocfg_pkg::MODE_IDLE)));
  end

  // Delivery delay per oscillator, in its own cycles
  assign avail[ocfg_pkg::CH_PLL]  = ocfg_pkg::PLL_AVAIL;
  assign avail[ocfg_pkg::CH_SLOW] = ocfg_pkg::SLOW_AVAIL;
  assign avail[ocfg_pkg::CH_XTAL] = ocfg_pkg::XTAL_AVAIL;

  // Per-oscillator sync, edge detect and grant counter
  genvar c;
  generate
    for (c = 0; c < ocfg_pkg::N_CH; c++) begin : g_ch
      logic [2:0] cnt;
      logic       ready_src;

      ocfg_sync u_sync (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_async   (i_osc_clk[c]),
        .o_level   (osc_level[c])
      );

      assign osc_rise[c] = osc_level[c] && !osc_level_d[c];
      assign ready_src   = (c == ocfg_pkg::CH_XTAL) ? xtal_stable : 1'b1;

      // Count oscillator edges while requested and running
      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          osc_level_d[c] <= 1'b0;
          cnt            <= 3'h0;
          o_osc_grant[c] <= 1'b0;
          o_osc_run[c]   <= 1'b0;
        end else begin
          osc_level_d[c] <= osc_level[c];
          o_osc_run[c]   <= run[c];
          if (!(i_osc_req[c] && run[c] && ready_src)) begin
            cnt            <= 3'h0;
            o_osc_grant[c] <= 1'b0;
          end else if (osc_rise[c] && cnt != avail[c]) begin
            cnt            <= cnt + 3'h1;
            o_osc_grant[c] <= (cnt + 3'h1) == avail[c];
          end
        end
      end
    end
  endgenerate

  // Start-up length chosen by code
  always_comb begin
    unique case (xtal.crystal_startup_cycles)
      2'h0: su_target = 17'(SU_1K);
      2'h1: su_target = 17'(SU_16K);
      2'h2: su_target = 17'(SU_32K);
      2'h3: su_target = 17'(SU_64K);
    endcase
  end

  // Crystal start-up counter; external clock skips the wait
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      su_count    <= 17'h0_0000;
      xtal_stable <= 1'b0;
    end else if (!run[ocfg_pkg::CH_XTAL]) begin
      su_count    <= 17'h0_0000;
      xtal_stable <= 1'b0;
    end else if (osc_rise[ocfg_pkg::CH_XTAL] && !xtal_stable) begin
      if (xtal.external_clock_in || su_count + 17'h0_0001 >= su_target) begin
        xtal_stable <= 1'b1;
      end
      su_count <= su_count + 17'h0_0001;
    end
  end

  // Registered configuration outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_fast_trim                <= ocfg_pkg::RST_TRIM;
      o_crystal_lock_trim_en     <= 1'b0;
      o_pll_src_external         <= 1'b0;
      o_pll_ratio_sel            <= ocfg_pkg::RATIO_OFF;
      o_low_power_drive          <= 1'b0;
      o_external_clock_in        <= 1'b0;
      o_crystal_pin_takeover     <= 1'b0;
      o_slow_crystal_stable_flag <= 1'b0;
    end else begin
      o_fast_trim                <= trim;
      o_crystal_lock_trim_en     <= auto_en;
      o_pll_src_external         <= pll.src_external;
      o_pll_ratio_sel            <= pll.pll_ratio_sel;
      o_low_power_drive          <= xtal.low_power_drive;
      o_external_clock_in        <= xtal.external_clock_in;
      o_crystal_pin_takeover     <= xtal.enable;
      o_slow_crystal_stable_flag <= xtal_stable;
    end
  end

  // Checks
  trim_lock_a: assert property (auto_en && !$rose(auto_en) |-> $stable(trim))
    else $error("trim changed while auto-tune on");

  trim_reload_a: assert property ($fell(auto_en) |-> trim == $past(i_auto_trim))
    else $error("trim not reloaded at auto-tune off");

  trim_mirror_a: assert property (o_pready && i_paddr == ocfg_pkg::OFF_TRIM && !o_pslverr
                                  |-> o_prdata[7:6] == {2{o_prdata[5]}})
    else $error("trim sign not mirrored");

  pll_off_a: assert property (pll.pll_ratio_sel == ocfg_pkg::RATIO_OFF
                              |=> !o_osc_run[ocfg_pkg::CH_PLL])
    else $error("pll runs while disabled");

  pll_keep_a: assert property (pll.keep_running_in_sleep && pll.pll_ratio_sel == ocfg_pkg::RATIO_X2
                               && mode == ocfg_pkg::MODE_STANDBY
                               |=> o_osc_run[ocfg_pkg::CH_PLL])
    else $error("pll not kept running");

  xtal_freeze_a: assert property (locked_xtal |=> $stable(xtal.crystal_startup_cycles)
                                  && $stable(xtal.external_clock_in))
    else $error("frozen crystal field changed");

  protect_a: assert property (!i_cfg_unlock |=> $stable(pll) && $stable(slow_keep))
    else $error("protected register written while locked");

  pll_grant_a: assert property ($rose(o_osc_grant[ocfg_pkg::CH_PLL])
                                |-> g_ch[0].cnt == ocfg_pkg::PLL_AVAIL)
    else $error("pll granted at wrong edge count");

  slow_grant_a: assert property ($rose(o_osc_grant[ocfg_pkg::CH_SLOW])
                                 |-> g_ch[1].cnt == ocfg_pkg::SLOW_AVAIL)
    else $error("slow oscillator granted at wrong edge count");

  xtal_grant_a: assert property (o_osc_grant[ocfg_pkg::CH_XTAL] |-> $past(xtal_stable))
    else $error("crystal granted before start-up");

  xtal_run_a: assert property (!xtal.enable |=> !o_osc_run[ocfg_pkg::CH_XTAL])
    else $error("crystal runs while disabled");

  pins_a: assert property (xtal.enable |=> o_crystal_pin_takeover)
    else $error("crystal pins not taken over");

  slow_keep_a: assert property (slow_keep |=> o_osc_run[ocfg_pkg::CH_SLOW])
    else $error("slow oscillator not kept running");

  xtal_startup_a: assert property ($rose(xtal_stable) && !xtal.external_clock_in
                                   |-> su_count >= su_target)
    else $error("crystal stable before start-up count");

endmodule : ocfg_regs

//--- testbench.sv
// Self-checking bench for the oscillator and PLL configuration registers
`timescale 1ns/10ps
module testbench;
  logic        i_ref_clk;
  logic        i_reset;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        i_cfg_unlock;
  logic [1:0]  i_sleep_mode;
  logic [5:0]  i_auto_trim;
  logic [2:0]  i_osc_req;
  logic [2:0]  i_osc_clk;
  logic [5:0]  o_fast_trim;
  logic        o_crystal_lock_trim_en;
  logic        o_pll_src_external;
  logic [1:0]  o_pll_ratio_sel;
  logic        o_low_power_drive;
  logic        o_external_clock_in;
  logic        o_crystal_pin_takeover;
  logic        o_slow_crystal_stable_flag;
  logic [2:0]  o_osc_run;
  logic [2:0]  o_osc_grant;
  int          bad_count;
  int          n_tests;

  // Short start-up counts keep the crystal wait brief
  ocfg_regs #(.SU_1K(4), .SU_16K(8), .SU_32K(12), .SU_64K(16)) dut (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_cfg_unlock(i_cfg_unlock),
    .i_sleep_mode(i_sleep_mode), .i_auto_trim(i_auto_trim), .i_osc_req(i_osc_req),
    .i_osc_clk(i_osc_clk), .o_fast_trim(o_fast_trim),
    .o_crystal_lock_trim_en(o_crystal_lock_trim_en),
    .o_pll_src_external(o_pll_src_external), .o_pll_ratio_sel(o_pll_ratio_sel),
    .o_low_power_drive(o_low_power_drive), .o_external_clock_in(o_external_clock_in),
    .o_crystal_pin_takeover(o_crystal_pin_takeover),
    .o_slow_crystal_stable_flag(o_slow_crystal_stable_flag),
    .o_osc_run(o_osc_run), .o_osc_grant(o_osc_grant));

  // 10 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // Verdict and end of run
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task ticks(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : ticks

  // One oscillator pulse, long enough to pass the synchroniser
  task osc_pulse(input int ch);
    i_osc_clk[ch] <= 1'b1;
    ticks(6);
    i_osc_clk[ch] <= 1'b0;
    ticks(5);
  endtask : osc_pulse

  // One APB transfer: setup, then access held until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int k;
    @(posedge i_ref_clk);
    i_psel    <= 1'b1;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_ref_clk);
      if (o_pready === 1'b1) break;
    end
    q = o_prdata;
    e = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    if (k == 20) begin
      bad_count++;
      test_done();
    end
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("read data", exp, q);
    chk("slave error", {31'h0, exp_err}, {31'h0, e});
  endtask : rd

  // Request an oscillator and count its rises until the grant shows
  task osc_count(input int ch, input int exp, input logic upto);
    int n;
    i_osc_req[ch] <= 1'b1;
    ticks(2);
    for (n = 0; n < 12; n++) begin
      @(posedge i_ref_clk);
      if (o_osc_grant[ch] === 1'b1) break;
      osc_pulse(ch);
    end
    if (upto) chk("grant within", 32'h1, {31'h0, n <= exp});
    else chk("grant rises", exp, n);
    i_osc_req[ch] <= 1'b0;
    ticks(3);
    chk("grant drop", 32'h0, {31'h0, o_osc_grant[ch]});
  endtask : osc_count

  task t_reset;
    rd(ocfg_pkg::OFF_PLL, 32'h0, 1'b0);
    rd(ocfg_pkg::OFF_SLOW_INT, 32'h0, 1'b0);
    rd(ocfg_pkg::OFF_XTAL, 32'h0, 1'b0);
    rd(ocfg_pkg::OFF_TRIM, 32'h0, 1'b0);
    rd(8'h04, 32'h0, 1'b1);
    rd(8'h11, 32'h0, 1'b1);
  endtask : t_reset

  task t_trim;
    wr(ocfg_pkg::OFF_TRIM, 32'h1f);
    rd(ocfg_pkg::OFF_TRIM, 32'h1f, 1'b0);
    wr(ocfg_pkg::OFF_TRIM, 32'h20);
    rd(ocfg_pkg::OFF_TRIM, 32'he0, 1'b0);
    chk("trim out", 32'h20, {26'h0, o_fast_trim});
    wr(ocfg_pkg::OFF_TRIM, 32'hdf);
    rd(ocfg_pkg::OFF_TRIM, 32'h1f, 1'b0);
  endtask : t_trim

  task t_auto;
    int k;
    wr(ocfg_pkg::OFF_FAST, 32'h1);
    ticks(2);
    chk("auto enable", 32'h1, {31'h0, o_crystal_lock_trim_en});
    wr(ocfg_pkg::OFF_TRIM, 32'h05);
    rd(ocfg_pkg::OFF_TRIM, 32'h1f, 1'b0);
    i_auto_trim <= 6'h2a;
    wr(ocfg_pkg::OFF_FAST, 32'h0);
    for (k = 0; k < ocfg_pkg::TRIM_REFRESH_CYC; k++) begin
      if (o_fast_trim === 6'h2a) break;
      @(posedge i_ref_clk);
    end
    chk("trim refresh", 32'h1, {31'h0, k < ocfg_pkg::TRIM_REFRESH_CYC});
    rd(ocfg_pkg::OFF_TRIM, 32'hea, 1'b0);
  endtask : t_auto

  task t_pll;
    int c;
    i_cfg_unlock <= 1'b0;
    wr(ocfg_pkg::OFF_PLL, 32'h41);
    rd(ocfg_pkg::OFF_PLL, 32'h0, 1'b0);
    i_cfg_unlock <= 1'b1;
    i_sleep_mode <= ocfg_pkg::MODE_STANDBY;
    for (c = 0; c < 4; c++) begin
      wr(ocfg_pkg::OFF_PLL, {24'h0, 6'h30, c[1:0]});
      rd(ocfg_pkg::OFF_PLL, {24'h0, 6'h30, c[1:0]}, 1'b0);
      chk("ratio out", {30'h0, c[1:0]}, {30'h0, o_pll_ratio_sel});
      chk("pll source", 32'h1, {31'h0, o_pll_src_external});
      chk("pll run", {31'h0, c == 1 || c == 2}, {31'h0, o_osc_run[0]});
    end
    wr(ocfg_pkg::OFF_PLL, 32'h81);
    ticks(3);
    chk("pll run standby", 32'h1, {31'h0, o_osc_run[0]});
    wr(ocfg_pkg::OFF_PLL, 32'h01);
    i_sleep_mode <= ocfg_pkg::MODE_ACTIVE;
    ticks(3);
    chk("pll idle no request", 32'h0, {31'h0, o_osc_run[0]});
    chk("pll source", 32'h0, {31'h0, o_pll_src_external});
  endtask : t_pll

  task t_slow;
    i_sleep_mode <= ocfg_pkg::MODE_PDOWN;
    wr(ocfg_pkg::OFF_SLOW_INT, 32'h80);
    ticks(3);
    chk("slow run", 32'h1, {31'h0, o_osc_run[1]});
    wr(ocfg_pkg::OFF_SLOW_INT, 32'h00);
    ticks(3);
    chk("slow stop", 32'h0, {31'h0, o_osc_run[1]});
    i_sleep_mode <= ocfg_pkg::MODE_ACTIVE;
    osc_count(0, 2, 1'b0);
    osc_count(1, 4, 1'b0);
  endtask : t_slow

  task t_xtal;
    int n;
    wr(ocfg_pkg::OFF_XTAL, 32'h36);
    rd(ocfg_pkg::OFF_XTAL, 32'h36, 1'b0);
    chk("ext clock", 32'h1, {31'h0, o_external_clock_in});
    chk("low power", 32'h1, {31'h0, o_low_power_drive});
    chk("pins idle", 32'h0, {31'h0, o_crystal_pin_takeover});
    wr(ocfg_pkg::OFF_XTAL, 32'h83);
    wr(ocfg_pkg::OFF_XTAL, 32'hb7);
    rd(ocfg_pkg::OFF_XTAL, 32'h83, 1'b0);
    chk("pins taken", 32'h1, {31'h0, o_crystal_pin_takeover});
    chk("ext clock", 32'h0, {31'h0, o_external_clock_in});
    chk("crystal run", 32'h1, {31'h0, o_osc_run[2]});
    // Crystal start-up of four cycles with code 0
    for (n = 0; n < 40; n++) begin
      @(posedge i_ref_clk);
      if (o_slow_crystal_stable_flag === 1'b1) break;
      osc_pulse(2);
    end
    chk("start-up rises", 32'h4, n);
    osc_count(2, 3, 1'b1);
    // Keep bit clear: runs on request in active and idle only
    wr(ocfg_pkg::OFF_XTAL, 32'h03);
    i_osc_req[2] <= 1'b1;
    i_sleep_mode <= ocfg_pkg::MODE_STANDBY;
    ticks(3);
    chk("crystal standby", 32'h0, {31'h0, o_osc_run[2]});
    i_sleep_mode <= ocfg_pkg::MODE_IDLE;
    ticks(3);
    chk("crystal idle", 32'h1, {31'h0, o_osc_run[2]});
    i_osc_req[2] <= 1'b0;
    i_sleep_mode <= ocfg_pkg::MODE_ACTIVE;
    // External clock source: stable at the first rise
    wr(ocfg_pkg::OFF_XTAL, 32'h00);
    wr(ocfg_pkg::OFF_XTAL, 32'h84);
    wr(ocfg_pkg::OFF_XTAL, 32'h85);
    chk("ext clock", 32'h1, {31'h0, o_external_clock_in});
    osc_pulse(2);
    chk("ext start-up", 32'h1, {31'h0, o_slow_crystal_stable_flag});
  endtask : t_xtal

  // Main sequence
  initial begin
    bad_count    = 0;
    n_tests      = 0;
    i_reset      = 1'b1;
    i_psel       = 1'b0;
    i_penable    = 1'b0;
    i_pwrite     = 1'b0;
    i_paddr      = 8'h00;
    i_pwdata     = 32'h0;
    i_cfg_unlock = 1'b1;
    i_sleep_mode = 2'h0;
    i_auto_trim  = 6'h00;
    i_osc_req    = 3'h0;
    i_osc_clk    = 3'h0;
    ticks(3);
    i_reset <= 1'b0;
    t_reset();
    t_trim();
    t_auto();
    t_pll();
    t_slow();
    t_xtal();
    test_done();
  end
endmodule : testbench
